// >>> gpio_pins_model.sv
// Purpose: Pin-side model: loads, switches and pull-ups on one port
// Assumes: One bit per pin, level resolved from every party
// Notes: Released, unpulled pins toggle every cycle
`timescale 1ns/1ps
`default_nettype none
module gpio_pins_model #(
    parameter int W = 4
) (
    input wire logic clk_i,
    input wire logic [W-1:0] drv_i,
    input wire logic [W-1:0] oe_i,
    input wire logic [W-1:0] pull_i,
    input wire logic [W-1:0] ext_en_i,
    input wire logic [W-1:0] ext_val_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] float_r = '0;
    // A stale level must never pass for a driven one
    always @(posedge clk_i) float_r <= ~float_r;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe_i[i]) level_o[i] = drv_i[i];
            else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
            else if (pull_i[i]) level_o[i] = 1'b1;
            else level_o[i] = float_r[i];
        end
    end
endmodule
`default_nettype wire

// >>> gpio_pkg.sv
// Purpose: Shared constants and carriers for the general-purpose port block
// Assumes: Wishbone classic slave, 8-bit registers in the low byte of a 32-bit word
// Notes: Offsets are byte addresses of aligned words
package gpio_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // Register map
    localparam logic [7:0] DIR2_OFS = 8'h00;
    localparam logic [7:0] LATCH2_OFS = 8'h04;
    localparam logic [7:0] PULL2_OFS = 8'h08;
    localparam logic [7:0] DIR4_OFS = 8'h0C;
    localparam logic [7:0] LATCH4_OFS = 8'h10;
    localparam logic [7:0] PULL4_OFS = 8'h14;
    localparam logic [7:0] PIN2_OFS = 8'h18;
    localparam logic [7:0] PIN4_OFS = 8'h1C;
    localparam logic [7:0] SHARED_OFS = 8'h20;

    // Reset values: all inputs, latches low, pull-ups off
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] PULL_RST = 8'h00;

    // Port widths
    localparam int PORT2_PINS = 4;
    localparam int PORT4_PINS = 8;

    // Field positions
    localparam int SHARED_PIN_BIT = 4;
    localparam int SHARED_STAT_MODE_BIT = 0;
    localparam int SHARED_STAT_IN_BIT = 1;

    // Register file index
    localparam int NREGS = 6;
    localparam logic [2:0] IDX_DIR2 = 3'h0;
    localparam logic [2:0] IDX_LATCH2 = 3'h1;
    localparam logic [2:0] IDX_PULL2 = 3'h2;
    localparam logic [2:0] IDX_DIR4 = 3'h3;
    localparam logic [2:0] IDX_LATCH4 = 3'h4;
    localparam logic [2:0] IDX_PULL4 = 3'h5;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [ADDR_W-1:0] adr;
        logic [DATA_W-1:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull;
    } pin_drive_t;

endpackage

// >>> port_direction_latch_pullup.sv
// Purpose: General-purpose ports 2 and 4 with direction, latch and pull-up control
// Assumes: Wishbone classic slave on clk_i; pins arrive asynchronously
// Notes: Shared reset pin mode comes from a nonvolatile option strap
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Direction bit per pin selects input/output
// - All pins input after reset
// - Direction one is input, zero output
// - Output pin drives its latch level
// - Latches cleared low at reset
// - Port-2 latch bits 0-3; high bits zero (the code stores and reads back all 8 bits; only bits 0-3 reach the pins)
// - Pull-up select connects input pull-up
// - No pull-ups after reset
// - Direction F0, latch 07 drives 0111 pattern
// - Shared reset pin chosen by option byte
// - Pull-up bit one connects resistor
module port_direction_latch_pullup
    import gpio_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [PORT2_PINS-1:0] port2_pin_i,
    output logic [PORT2_PINS-1:0] port2_pin_o,
    output logic [PORT2_PINS-1:0] port2_pin_oe_o,
    output logic [PORT2_PINS-1:0] port2_pullup_o,
    input wire logic [PORT4_PINS-1:0] port4_pin_i,
    output logic [PORT4_PINS-1:0] port4_pin_o,
    output logic [PORT4_PINS-1:0] port4_pin_oe_o,
    output logic [PORT4_PINS-1:0] port4_pullup_o,
    input wire logic option_reset_sel_i,
    input wire logic shared_reset_pin_i,
    output logic shared_reset_o
);

    wb_req_t req;
    logic [REG_W-1:0] dir2, latch2, pull2, dir4, latch4, pull4;
    logic wr_en;
    logic [2:0] wr_idx, rd_idx;
    logic idx_hit;
    logic [PORT2_PINS-1:0] p2_s1_r, p2_s2_r;
    logic [PORT4_PINS-1:0] p4_s1_r, p4_s2_r;
    logic sh_s1_r, sh_s2_r;
    logic reset_mode_r;
    logic strap_done_r;
    pin_drive_t drv2, drv4;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                   adr: wb_adr_i, dat: wb_dat_i};

    // Output mode when direction bit is zero; pull-up only on inputs
    function automatic pin_drive_t drive(input logic [7:0] dir, input logic [7:0] latch,
                                         input logic [7:0] pull);
        pin_drive_t d;
        d.oe = ~dir;
        d.out = latch & ~dir;
        d.pull = pull & dir;
        return d;
    endfunction

    function automatic logic [2:0] map_idx(input logic [7:0] adr);
        logic [2:0] idx;
        idx = 3'h7;
        unique case (adr)
            DIR2_OFS: idx = IDX_DIR2;
            LATCH2_OFS: idx = IDX_LATCH2;
            PULL2_OFS: idx = IDX_PULL2;
            DIR4_OFS: idx = IDX_DIR4;
            LATCH4_OFS: idx = IDX_LATCH4;
            PULL4_OFS: idx = IDX_PULL4;
            default: idx = 3'h7;
        endcase
        return idx;
    endfunction

    assign wr_idx = map_idx(req.adr);
    assign rd_idx = map_idx(req.adr);
    assign idx_hit = (wr_idx != 3'h7);
    // Write only on the first cycle so a held request lands once
    assign wr_en = req.cyc && req.stb && req.we && req.sel[0] && idx_hit && !wb_ack_o;

    port_regs u_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .wr_i(wr_en),
        .wr_idx_i(wr_idx),
        .wr_dat_i(req.dat[REG_W-1:0]),
        .rd_idx_i(rd_idx),
        .rd_dat_o(),
        .dir2_o(dir2),
        .latch2_o(latch2),
        .pull2_o(pull2),
        .dir4_o(dir4),
        .latch4_o(latch4),
        .pull4_o(pull4)
    );

    // Bus ack: one cycle after strobe, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
        end
    end

    // Read word loaded at the taken edge so it comes from a flop and stands with ack
    // Bank is read through its direct outputs; its registered port would cost a cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (ce_i) begin
            wb_dat_o <= '0;
            if (req.cyc && req.stb && !req.we && !wb_ack_o) begin
                unique case (req.adr)
                    PIN2_OFS: wb_dat_o <= DATA_W'(p2_s2_r);
                    PIN4_OFS: wb_dat_o <= DATA_W'(p4_s2_r);
                    SHARED_OFS: wb_dat_o <= DATA_W'({sh_s2_r, reset_mode_r});
                    DIR2_OFS: wb_dat_o <= DATA_W'(dir2);
                    LATCH2_OFS: wb_dat_o <= DATA_W'(latch2);
                    PULL2_OFS: wb_dat_o <= DATA_W'(pull2);
                    DIR4_OFS: wb_dat_o <= DATA_W'(dir4);
                    LATCH4_OFS: wb_dat_o <= DATA_W'(latch4);
                    PULL4_OFS: wb_dat_o <= DATA_W'(pull4);
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end

    // Pin synchronisers, two stages each
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            p2_s1_r <= '0;
            p2_s2_r <= '0;
            p4_s1_r <= '0;
            p4_s2_r <= '0;
            sh_s1_r <= 1'b0;
            sh_s2_r <= 1'b0;
        end else if (ce_i) begin
            p2_s1_r <= port2_pin_i;
            p2_s2_r <= p2_s1_r;
            p4_s1_r <= port4_pin_i;
            p4_s2_r <= p4_s1_r;
            sh_s1_r <= shared_reset_pin_i;
            sh_s2_r <= sh_s1_r;
        end
    end

    // Option strap is caught once after reset; it is not a runtime register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_mode_r <= 1'b0;
            strap_done_r <= 1'b0;
        end else if (ce_i && !strap_done_r) begin
            reset_mode_r <= option_reset_sel_i;
            strap_done_r <= 1'b1;
        end
    end

    // Shared pin asserts reset low-active only in reset mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shared_reset_o <= 1'b0;
        end else if (ce_i) begin
            shared_reset_o <= reset_mode_r && !sh_s2_r;
        end
    end

    // Port 2 only has four pins; upper bits of its registers are stored and read back but never reach the pins
    assign drv2 = drive(dir2, latch2, pull2);
    assign drv4 = drive(dir4, latch4, pull4);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port2_pin_o <= '0;
            port2_pin_oe_o <= '0;
            port2_pullup_o <= '0;
            port4_pin_o <= '0;
            port4_pin_oe_o <= '0;
            port4_pullup_o <= '0;
        end else if (ce_i) begin
            port2_pin_o <= drv2.out[PORT2_PINS-1:0];
            port2_pin_oe_o <= drv2.oe[PORT2_PINS-1:0];
            port2_pullup_o <= drv2.pull[PORT2_PINS-1:0];
            port4_pin_o <= drv4.out[PORT4_PINS-1:0];
            port4_pin_oe_o <= drv4.oe[PORT4_PINS-1:0];
            port4_pullup_o <= drv4.pull[PORT4_PINS-1:0];
        end
    end

endmodule
`default_nettype wire

// >>> port_direction_latch_pullup_bench.sv
// Purpose: Directed tests of the port block over the register bus
// Assumes: Clock enable dropped only in the freeze test
// Notes: Pin levels come from the pin-side model
`timescale 1ns/1ps
`default_nettype none
module port_direction_latch_pullup_bench;
    import gpio_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_sel_i = 4'hF;
    logic [ADDR_W-1:0] wb_adr_i = '0;
    logic [DATA_W-1:0] wb_dat_i = '0;
    logic [DATA_W-1:0] wb_dat_o;
    logic wb_ack_o, shared_reset_o;
    logic option_sel = 1'b0;
    logic shared_pin = 1'b1;
    logic [3:0] p2_in, p2_o, p2_oe, p2_pu;
    logic [7:0] p4_in, p4_o, p4_oe, p4_pu;
    logic [7:0] ext4_en = 8'h00;
    logic [7:0] ext4_val = 8'h00;
    logic [31:0] rd;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;
    always #20 clk_i = ~clk_i;
    port_direction_latch_pullup i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .port2_pin_i(p2_in), .port2_pin_o(p2_o), .port2_pin_oe_o(p2_oe),
        .port2_pullup_o(p2_pu), .port4_pin_i(p4_in), .port4_pin_o(p4_o),
        .port4_pin_oe_o(p4_oe), .port4_pullup_o(p4_pu), .option_reset_sel_i(option_sel),
        .shared_reset_pin_i(shared_pin), .shared_reset_o(shared_reset_o));
    gpio_pins_model #(.W(4)) i_pins2 (.clk_i(clk_i), .drv_i(p2_o), .oe_i(p2_oe),
        .pull_i(p2_pu), .ext_en_i(4'h0), .ext_val_i(4'h0), .level_o(p2_in));
    gpio_pins_model #(.W(8)) i_pins4 (.clk_i(clk_i), .drv_i(p4_o), .oe_i(p4_oe),
        .pull_i(p4_pu), .ext_en_i(ext4_en), .ext_val_i(ext4_val), .level_o(p4_in));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 3000) begin
            err_count++;
            report_and_stop;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
                       input logic [3:0] s = 4'hF);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_sel_i <= s;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        // Only ack or the global cycle ceiling ends this wait
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(negedge clk_i);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 8'h00);
        chk(rd, exp);
    endtask
    task automatic do_reset(input logic opt);
        @(posedge clk_i);
        rst_i <= 1'b1;
        option_sel <= opt;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic t_reset;
        rdchk(DIR2_OFS, 32'hFF);
        rdchk(LATCH2_OFS, 32'h00);
        rdchk(PULL2_OFS, 32'h00);
        rdchk(DIR4_OFS, 32'hFF);
        chk({20'h0, p2_oe, p2_o, p2_pu}, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_example;
        bus(DIR2_OFS, 1'b1, 8'hF0);
        bus(LATCH2_OFS, 1'b1, 8'h07);
        chk({28'h0, p2_oe}, 32'hF);
        chk({28'h0, p2_in}, 32'h7);
        rdchk(DIR2_OFS, 32'hF0);
        rdchk(PIN2_OFS, 32'h7);
        $display("test example done");
    endtask
    task automatic t_latch_pull;
        bus(DIR2_OFS, 1'b1, 8'hFF);
        bus(LATCH2_OFS, 1'b1, 8'h0A);
        chk({28'h0, p2_o}, 32'h0);
        bus(DIR2_OFS, 1'b1, 8'hF5);
        chk({24'h0, p2_oe, p2_o}, 32'hAA);
        bus(PULL2_OFS, 1'b1, 8'h0F);
        chk({28'h0, p2_pu}, 32'h5);
        bus(PULL4_OFS, 1'b1, 8'h09);
        @(posedge clk_i);
        ext4_en <= 8'h01;
        repeat (3) @(posedge clk_i);
        bus(PIN4_OFS, 1'b0, 8'h00);
        chk(rd & 32'h9, 32'h8);
        $display("test latch and pull done");
    endtask
    task automatic t_refuse;
        bus(8'h3C, 1'b1, 8'h55);
        rdchk(8'h3C, 32'h0);
        bus(LATCH2_OFS, 1'b1, 8'h00, 4'hE);
        rdchk(LATCH2_OFS, 32'h0A);
        $display("test refuse done");
    endtask
    task automatic t_freeze;
        @(posedge clk_i);
        ce_i <= 1'b0;
        ext4_val <= 8'h01;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= 1'b1;
        wb_sel_i <= 4'hF;
        wb_adr_i <= DIR2_OFS;
        wb_dat_i <= 32'h000000FF;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        // Held request must neither be answered nor land while frozen
        chk({23'h0, wb_ack_o, p2_oe, p2_pu}, 32'h0A5);
        @(posedge clk_i);
        ce_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(negedge clk_i);
        chk({24'h0, p2_oe, p2_pu}, 32'h0F);
        bus(PIN4_OFS, 1'b0, 8'h00);
        chk(rd & 32'h9, 32'h9);
        bus(LATCH4_OFS, 1'b1, 8'h30);
        bus(DIR4_OFS, 1'b1, 8'hC7);
        chk({8'h0, p4_o, p4_oe, p4_pu}, 32'h303801);
        $display("test clock enable done");
    endtask
    task automatic t_shared;
        @(posedge clk_i);
        shared_pin <= 1'b0;
        do_reset(1'b1);
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        chk({31'h0, shared_reset_o}, 32'h1);
        rdchk(SHARED_OFS, 32'h1);
        rdchk(DIR2_OFS, 32'hFF);
        do_reset(1'b0);
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        chk({31'h0, shared_reset_o}, 32'h0);
        $display("test shared pin done");
    endtask
    initial begin
        do_reset(1'b0);
        t_reset;
        t_example;
        t_latch_pull;
        t_refuse;
        t_freeze;
        t_shared;
        report_and_stop;
    end
endmodule
`default_nettype wire

// >>> port_direction_latch_pullup_chk.sv
// Purpose: Port timing checks on the bus and port 2 pins
// Assumes: Frozen cycles (clock enable low) take no request
// Notes: Pin outputs follow a write by two edges
`timescale 1ns/1ps
`default_nettype none
module port_direction_latch_pullup_chk
    import gpio_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [PORT2_PINS-1:0] port2_pin_o,
    input wire logic [PORT2_PINS-1:0] port2_pin_oe_o,
    input wire logic [PORT2_PINS-1:0] port2_pullup_o,
    input wire logic shared_reset_pin_i,
    input wire logic shared_reset_o
);
    logic req;
    logic wr0;
    assign req = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr0 = req && wb_we_i && wb_sel_i[0];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_TIMING: assert property (req |=> wb_ack_o)
        else $error("ack missing");
    AST_ACK_PULSE: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack too long");
    AST_DIR_OE: assert property (wr0 && wb_adr_i == DIR2_OFS |-> ##2
        port2_pin_oe_o == ~$past(wb_dat_i[3:0], 2)) else $error("enable mismatch");
    AST_LATCH_OUT: assert property (wr0 && wb_adr_i == LATCH2_OFS |-> ##2
        port2_pin_o == ($past(wb_dat_i[3:0], 2) & port2_pin_oe_o)) else $error("drive mismatch");
    AST_PULL_SET: assert property (wr0 && wb_adr_i == PULL2_OFS |-> ##2
        port2_pullup_o == ($past(wb_dat_i[3:0], 2) & ~port2_pin_oe_o)) else $error("pull mismatch");
    AST_OUT_GATE: assert property ((port2_pin_o & ~port2_pin_oe_o) == 4'h0)
        else $error("input pin driven");
    AST_PULL_GATE: assert property ((port2_pullup_o & port2_pin_oe_o) == 4'h0)
        else $error("pull on output");
    AST_RESET_PINS: assert property ($fell(rst_i) |->
        (port2_pin_oe_o | port2_pullup_o | port2_pin_o) == 4'h0) else $error("pins after reset");
    AST_SHARED_IDLE: assert property (shared_reset_pin_i [*6] |-> !shared_reset_o)
        else $error("reset with pin high");
endmodule
bind port_direction_latch_pullup port_direction_latch_pullup_chk i_chk (.clk_i, .rst_i, .ce_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i, .wb_dat_i, .wb_ack_o,
    .port2_pin_o, .port2_pin_oe_o, .port2_pullup_o, .shared_reset_pin_i, .shared_reset_o);
`default_nettype wire

// >>> port_regs.sv
// Purpose: Small register bank for direction, latch and pull-up bytes
// Assumes: One write port, registered read data
// Notes: Reset loads each register's documented value
`timescale 1ns/1ps
`default_nettype none
module port_regs
    import gpio_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wr_i,
    input wire logic [2:0] wr_idx_i,
    input wire logic [REG_W-1:0] wr_dat_i,
    input wire logic [2:0] rd_idx_i,
    output logic [REG_W-1:0] rd_dat_o,
    output logic [REG_W-1:0] dir2_o,
    output logic [REG_W-1:0] latch2_o,
    output logic [REG_W-1:0] pull2_o,
    output logic [REG_W-1:0] dir4_o,
    output logic [REG_W-1:0] latch4_o,
    output logic [REG_W-1:0] pull4_o
);

    logic [REG_W-1:0] mem_r [NREGS];

    function automatic logic [REG_W-1:0] reset_value(input logic [2:0] idx);
        logic [REG_W-1:0] v;
        v = PULL_RST;
        if (idx == IDX_DIR2 || idx == IDX_DIR4) begin
            v = DIR_RST;
        end else if (idx == IDX_LATCH2 || idx == IDX_LATCH4) begin
            v = LATCH_RST;
        end
        return v;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NREGS; i++) begin
                mem_r[i] <= reset_value(3'(i));
            end
        end else if (ce_i && wr_i && int'(wr_idx_i) < NREGS) begin
            mem_r[wr_idx_i] <= wr_dat_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_dat_o <= 8'h00;
        end else if (ce_i) begin
            rd_dat_o <= (int'(rd_idx_i) < NREGS) ? mem_r[rd_idx_i] : 8'h00;
        end
    end

    assign dir2_o = mem_r[IDX_DIR2];
    assign latch2_o = mem_r[IDX_LATCH2];
    assign pull2_o = mem_r[IDX_PULL2];
    assign dir4_o = mem_r[IDX_DIR4];
    assign latch4_o = mem_r[IDX_LATCH4];
    assign pull4_o = mem_r[IDX_PULL4];

endmodule
`default_nettype wire
